// ===== rtl/tx_frame_fifo_pointer_config.sv
// configuration bank of the transmit frame processor: indirect pointer
// ram access, global dma sizing, octet bit order and lsb stuffing
// assumes a register master on clk that never overlaps its strobes
//
// How it works
// [RULE1] select write starts indirect access at index
// [RULE2] direction zero writes data register into ram
// [RULE3] direction one reads entry into data register
// [RULE4] busy set on start, cleared on completion
// [RULE5] software polls busy before using results
// [RULE6] entry holds next block index, low bits
// [RULE7] software links each channel into circle
// [RULE8] data field keeps written value until read
// [RULE9] software rewrites all links when provisioning
// [RULE10] software keeps reserved data bit zero
// [RULE11] burst field is max blocks minus one
// [RULE12] limit only for one-block channels when enabled
// [RULE13] enabled limit lets one-block amounts merge
// [RULE14] limit disabled means exactly one block
// [RULE15] order low sends byte lsb first
// [RULE16] order high sends byte msb first
// [RULE17] stuffing mode forces last octet bit
// [RULE18] global settings shared by every channel
// [RULE19] transfer size field means value plus one
// [RULE20] ram holds 512 nine-bit entries
// [RULE21] select writes ignored while busy
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tx_frame_fifo_pointer_config
  import tx_cfg_pkg::*;
#(
  parameter int PTR_ENTRIES = tx_cfg_pkg::PTR_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [tx_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tx_cfg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [tx_cfg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [2:0] transfer_size_field,
  output logic [3:0] dma_max_blocks,
  output logic dma_merge_allowed,
  input wire logic seven_bit_stuffing,
  input wire logic link_bit_tick,
  input wire logic [tx_cfg_pkg::OCTET_W-1:0] octet_data,
  input wire logic octet_valid,
  output logic octet_ready,
  output logic transmit_link_data_out,
  output logic transmit_link_bit_valid
);
  import tx_cfg_pkg::*;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic sel_hit;
  logic data_hit;
  logic cfg_hit;

  always_comb begin
    sel_hit = 1'b0;
    data_hit = 1'b0;
    cfg_hit = 1'b0;
    if (reg_addr == PTR_SELECT_OFFSET) begin
      sel_hit = 1'b1;
    end else if (reg_addr == PTR_DATA_OFFSET) begin
      data_hit = 1'b1;
    end else if (reg_addr == GLOBAL_CONFIG_OFFSET) begin
      cfg_hit = 1'b1;
    end
  end

  // ----------------------------------------
  // indirect access state
  // ----------------------------------------
  access_state_t state;
  access_state_t next_state;
  logic busy;
  logic access_dir;
  logic [PTR_W-1:0] access_index;
  logic [PTR_W-1:0] next_link_pointer;
  logic data_reserved;
  logic start_access;
  logic ram_we;
  logic ram_re;
  logic [PTR_W-1:0] ram_rdata;

  assign busy = (state != ACC_IDLE); // see [RULE4]
  // a select write while busy is dropped whole, index and direction kept
  assign start_access = reg_write && sel_hit && !busy; // see [RULE1] see [RULE21]

  // write needs one cycle, read two: ram issue, then capture
  always_comb begin
    next_state = state;
    case (state)
      ACC_IDLE: begin
        if (start_access) begin
          if (reg_wdata[SEL_DIR_BIT]) begin
            next_state = ACC_READ; // see [RULE3]
          end else begin
            next_state = ACC_WRITE; // see [RULE2]
          end
        end
      end
      ACC_WRITE: begin
        next_state = ACC_IDLE;
      end
      ACC_READ: begin
        next_state = ACC_CAPTURE;
      end
      ACC_CAPTURE: begin
        next_state = ACC_IDLE;
      end
      default: begin
        next_state = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ACC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // index and direction are latched only when an access is accepted
  always_ff @(posedge clk) begin
    if (rst) begin
      access_index <= PTR_RESET;
      access_dir <= CFG_BIT_RESET;
    end else if (start_access) begin
      access_index <= reg_wdata[SEL_INDEX_LSB +: PTR_W]; // see [RULE1]
      access_dir <= reg_wdata[SEL_DIR_BIT];
    end
  end

  // capture of a finished read beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      next_link_pointer <= PTR_RESET;
      data_reserved <= CFG_BIT_RESET;
    end else if (state == ACC_CAPTURE) begin
      next_link_pointer <= ram_rdata; // see [RULE3] see [RULE8]
    end else if (reg_write && data_hit) begin
      next_link_pointer <= reg_wdata[DATA_PTR_LSB +: PTR_W]; // see [RULE6] see [RULE8]
      data_reserved <= reg_wdata[DATA_RSVD_BIT];
    end
  end

  assign ram_we = (state == ACC_WRITE); // see [RULE2]
  assign ram_re = (state == ACC_READ); // see [RULE3]

  pointer_ram #(
    .DEPTH(PTR_ENTRIES),
    .WIDTH(PTR_W),
    .AW(PTR_W)
  ) u_pointer_ram ( // see [RULE20]
    .clk(clk),
    .write_en(ram_we),
    .read_en(ram_re),
    .addr(access_index),
    .write_data(next_link_pointer),
    .read_data(ram_rdata)
  );

  // ----------------------------------------
  // global configuration
  // ----------------------------------------
  logic [CFG_BURST_W-1:0] burst_length;
  logic length_limit_enable;
  logic msb_first_order;
  logic stuffed_lsb_value;

  always_ff @(posedge clk) begin
    if (rst) begin
      burst_length <= BURST_RESET;
      length_limit_enable <= CFG_BIT_RESET;
      msb_first_order <= CFG_BIT_RESET;
      stuffed_lsb_value <= CFG_BIT_RESET;
    end else if (reg_write && cfg_hit) begin
      burst_length <= reg_wdata[CFG_BURST_LSB +: CFG_BURST_W]; // see [RULE18]
      length_limit_enable <= reg_wdata[CFG_LEN_EN_BIT];
      msb_first_order <= reg_wdata[CFG_MSB_FIRST_BIT];
      stuffed_lsb_value <= reg_wdata[CFG_STUFF_BIT];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // unmapped offsets and unused bits read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= '0;
      if (sel_hit) begin
        reg_rdata[SEL_INDEX_LSB +: PTR_W] <= access_index;
        reg_rdata[SEL_DIR_BIT] <= access_dir;
        reg_rdata[SEL_BUSY_BIT] <= busy; // see [RULE4]
      end else if (data_hit) begin
        reg_rdata[DATA_PTR_LSB +: PTR_W] <= next_link_pointer; // see [RULE8]
        reg_rdata[DATA_RSVD_BIT] <= data_reserved;
      end else if (cfg_hit) begin
        reg_rdata[CFG_BURST_LSB +: CFG_BURST_W] <= burst_length;
        reg_rdata[CFG_LEN_EN_BIT] <= length_limit_enable;
        reg_rdata[CFG_MSB_FIRST_BIT] <= msb_first_order;
        reg_rdata[CFG_STUFF_BIT] <= stuffed_lsb_value;
      end
    end
  end

  // ----------------------------------------
  // dma transaction sizing
  // ----------------------------------------
  // same global limit for every channel, only the size field differs
  // limitation: one channel sized at a time, the caller muxes its field
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_max_blocks <= ONE_BLOCK;
      dma_merge_allowed <= 1'b0;
    end else if (transfer_size_field != XFER_ONE_BLOCK) begin
      dma_max_blocks <= {1'b0, transfer_size_field} + ONE_BLOCK; // see [RULE19] see [RULE12]
      dma_merge_allowed <= 1'b0;
    end else if (length_limit_enable) begin
      dma_max_blocks <= {1'b0, burst_length} + ONE_BLOCK; // see [RULE11] see [RULE13]
      dma_merge_allowed <= 1'b1;
    end else begin
      dma_max_blocks <= ONE_BLOCK; // see [RULE14]
      dma_merge_allowed <= 1'b0;
    end
  end

  // ----------------------------------------
  // octet serialiser
  // ----------------------------------------
  logic [OCTET_W-1:0] octet_reversed;
  logic [OCTET_W-1:0] shift_reg;
  logic [2:0] bit_count;
  logic octet_loaded;
  logic octet_take;

  for (genvar i = 0; i < OCTET_W; i++) begin : g_reverse
    assign octet_reversed[i] = octet_data[OCTET_W-1-i];
  end

  // one octet at a time; a gap of one tick between octets is accepted
  assign octet_ready = !octet_loaded;
  assign octet_take = octet_valid && octet_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= '0;
      octet_loaded <= 1'b0;
      bit_count <= '0;
    end else if (octet_take) begin
      if (msb_first_order) begin
        shift_reg <= octet_reversed; // see [RULE16]
      end else begin
        shift_reg <= octet_data; // see [RULE15]
      end
      octet_loaded <= 1'b1;
      bit_count <= '0;
    end else if (octet_loaded && link_bit_tick) begin
      shift_reg <= {1'b0, shift_reg[OCTET_W-1:1]};
      bit_count <= bit_count + 3'h1;
      if (bit_count == LAST_BIT_INDEX) begin
        octet_loaded <= 1'b0;
      end
    end
  end

  // stuffing mode is taken live, not latched with the octet
  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_link_data_out <= 1'b0;
      transmit_link_bit_valid <= 1'b0;
    end else if (octet_loaded && link_bit_tick) begin
      transmit_link_bit_valid <= 1'b1;
      if (seven_bit_stuffing && bit_count == LAST_BIT_INDEX) begin
        transmit_link_data_out <= stuffed_lsb_value; // see [RULE17]
      end else begin
        transmit_link_data_out <= shift_reg[0];
      end
    end else begin
      transmit_link_bit_valid <= 1'b0;
    end
  end

endmodule : tx_frame_fifo_pointer_config
`default_nettype wire

// ===== rtl/tx_cfg_pkg.sv
// shared constants for the transmit frame processor configuration bank
// assumes a single 25 MHz system clock and a plain strobe register port
package tx_cfg_pkg;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] PTR_SELECT_OFFSET = 12'h3A0;
  localparam logic [11:0] PTR_DATA_OFFSET = 12'h3A4;
  localparam logic [11:0] GLOBAL_CONFIG_OFFSET = 12'h3B0;

  // ----------------------------------------
  // pointer ram geometry
  // ----------------------------------------
  localparam int PTR_W = 9;
  localparam int PTR_DEPTH = 512;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SEL_INDEX_LSB = 0;
  localparam int SEL_DIR_BIT = 14;
  localparam int SEL_BUSY_BIT = 15;
  localparam int DATA_PTR_LSB = 0;
  localparam int DATA_RSVD_BIT = 15;
  localparam int CFG_BURST_LSB = 0;
  localparam int CFG_BURST_W = 3;
  localparam int CFG_LEN_EN_BIT = 7;
  localparam int CFG_MSB_FIRST_BIT = 8;
  localparam int CFG_STUFF_BIT = 9;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [8:0] PTR_RESET = 9'h000;
  localparam logic [2:0] BURST_RESET = 3'h0;
  localparam logic CFG_BIT_RESET = 1'b0;

  // ----------------------------------------
  // transfer sizing and octets
  // ----------------------------------------
  localparam logic [2:0] XFER_ONE_BLOCK = 3'h0;
  localparam logic [3:0] ONE_BLOCK = 4'h1;
  localparam int OCTET_W = 8;
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

  // ----------------------------------------
  // indirect access sequencer
  // ----------------------------------------
  typedef enum logic [3:0] {
    ACC_IDLE = 4'b0001,
    ACC_WRITE = 4'b0010,
    ACC_READ = 4'b0100,
    ACC_CAPTURE = 4'b1000
  } access_state_t;

endpackage : tx_cfg_pkg

// ===== rtl/pointer_ram.sv
// single port block pointer memory with registered read data
// assumes one clock; read data valid the cycle after the read enable
`timescale 1ns/1ps
`default_nettype none
module pointer_ram #(
  parameter int DEPTH = 512,
  parameter int WIDTH = 9,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic write_en,
  input wire logic read_en,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] write_data,
  output logic [WIDTH-1:0] read_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array: software must rewrite every link anyway
  always_ff @(posedge clk) begin
    if (write_en) begin
      mem[addr] <= write_data;
    end
  end

  always_ff @(posedge clk) begin
    if (read_en) begin
      read_data <= mem[addr];
    end
  end

endmodule : pointer_ram
`default_nettype wire

// ===== verification/tx_cfg_chk.sv
// port checker for the transmit configuration bank
// assumes bind onto the top module, one clock
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_chk
  import tx_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [tx_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tx_cfg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [tx_cfg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [2:0] transfer_size_field,
  input wire logic [3:0] dma_max_blocks,
  input wire logic dma_merge_allowed,
  input wire logic link_bit_tick,
  input wire logic octet_valid,
  input wire logic octet_ready,
  input wire logic transmit_link_bit_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff rst;
  logic cfg_w;
  logic cfg_r;
  assign cfg_w = reg_write && reg_addr == GLOBAL_CONFIG_OFFSET;
  assign cfg_r = reg_read && reg_addr == GLOBAL_CONFIG_OFFSET;
  sel_fields_a: assert property (reg_read && reg_addr == PTR_SELECT_OFFSET
    |=> (reg_rdata & 32'hFFFF3E00) == 32'h0) else $error("select unused bits set");
  rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved");
  size_plus_a: assert property (transfer_size_field != 3'h0
    |=> dma_max_blocks == {1'b0, $past(transfer_size_field)} + 4'h1) else $error("size wrong");
  no_merge_a: assert property (transfer_size_field != 3'h0 |=> !dma_merge_allowed)
    else $error("merge on sized channel");
  block_range_a: assert property (dma_max_blocks inside {[4'h1:4'h8]})
    else $error("block count out of range");
  bit_cause_a: assert property (transmit_link_bit_valid |-> $past(link_bit_tick))
    else $error("bit without tick");
  take_busy_a: assert property (octet_valid && octet_ready |=> !octet_ready)
    else $error("ready after take");
  cfg_back_a: assert property (cfg_w ##1 cfg_r
    |=> reg_rdata == ($past(reg_wdata, 2) & 32'h387)) else $error("config readback");
endmodule : tx_cfg_chk
bind tx_frame_fifo_pointer_config tx_cfg_chk chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .transfer_size_field(transfer_size_field), .dma_max_blocks(dma_max_blocks),
  .dma_merge_allowed(dma_merge_allowed), .link_bit_tick(link_bit_tick),
  .octet_valid(octet_valid), .octet_ready(octet_ready),
  .transmit_link_bit_valid(transmit_link_bit_valid));
`default_nettype wire

// ===== verification/link_partner.sv
// far side model: host byte source and link bit collector
// assumes send is a one-cycle pulse given only while idle
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic octet_ready,
  input wire logic line_bit,
  input wire logic line_valid,
  output logic octet_valid,
  output logic [7:0] octet_data,
  output logic link_bit_tick,
  output logic [7:0] rx_byte,
  output logic [3:0] rx_count
);
  logic [1:0] div;
  always_ff @(posedge clk) begin
    div <= rst ? 2'h0 : div + 2'h1;
    link_bit_tick <= !rst && div == 2'h3;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      octet_valid <= 1'b0;
      octet_data <= 8'h00;
    end else if (send) begin
      octet_valid <= 1'b1;
      octet_data <= send_byte;
    end else if (octet_valid && octet_ready) begin
      octet_valid <= 1'b0;
      // released byte flips so a stale value never looks right
      octet_data <= ~octet_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || send) begin
      rx_count <= 4'h0;
      rx_byte <= 8'h00;
    end else if (line_valid) begin
      rx_byte <= {rx_byte[6:0], line_bit};
      rx_count <= rx_count + 4'h1;
    end
  end
endmodule : link_partner
`default_nettype wire

// ===== verification/test_tx_frame_fifo_pointer_config.sv
// self-checking bench for the transmit configuration bank
// assumes the partner model feeds octets and link ticks
`timescale 1ns/1ps
`default_nettype none
module test_tx_frame_fifo_pointer_config;
  import tx_cfg_pkg::*;
  logic clk, rst, reg_write, reg_read, stuff_mode, o_valid, o_ready, tick, l_bit, l_valid;
  logic send, merge;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] xfer;
  logic [3:0] max_blk, rx_count;
  logic [7:0] o_data, send_byte, rx_byte;
  int err_total = 0;
  int num_checks = 0;
  tx_frame_fifo_pointer_config dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .transfer_size_field(xfer), .dma_max_blocks(max_blk), .dma_merge_allowed(merge),
    .seven_bit_stuffing(stuff_mode), .link_bit_tick(tick), .octet_data(o_data),
    .octet_valid(o_valid), .octet_ready(o_ready), .transmit_link_data_out(l_bit),
    .transmit_link_bit_valid(l_valid));
  link_partner partner_u (.clk(clk), .rst(rst), .send(send), .send_byte(send_byte),
    .octet_ready(o_ready), .line_bit(l_bit), .line_valid(l_valid), .octet_valid(o_valid),
    .octet_data(o_data), .link_bit_tick(tick), .rx_byte(rx_byte), .rx_count(rx_count));
  // ----
  // bus tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // strobe stays up so writes follow back to back; rd or the caller lowers it
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
  endtask : wr
  // read data stand from the cycle after the strobe until the next read, sampled mid-cycle
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    reg_write <= 1'b0;
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    q = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic wait_idle;
    logic [31:0] q;
    repeat (20) begin
      rd(PTR_SELECT_OFFSET, q);
      if (q[15] === 1'b0) break;
    end
    chk(q & 32'h8000, 32'h0);
  endtask : wait_idle
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    logic [31:0] q;
    logic [11:0] adr [4] = '{12'h3A0, 12'h3A4, 12'h3B0, 12'h3A8};
    foreach (adr[i]) begin
      rd(adr[i], q);
      chk(q, 32'h0);
    end
    chk({27'h0, merge, max_blk}, 32'h1);
    chk({31'h0, o_ready}, 32'h1);
  endtask : t_reset
  task automatic t_ptr;
    logic [31:0] q;
    // two blocks closed into a ring, every link rewritten, reserved bit low
    wr(PTR_DATA_OFFSET, 32'h1FF);
    wr(PTR_SELECT_OFFSET, 32'h0005);
    wait_idle();
    wr(PTR_DATA_OFFSET, 32'h005);
    wr(PTR_SELECT_OFFSET, 32'h01FF);
    wait_idle();
    wr(PTR_DATA_OFFSET, 32'h033);
    rd(PTR_DATA_OFFSET, q);
    chk(q, 32'h033);
    wr(PTR_SELECT_OFFSET, 32'h41FF);
    wr(PTR_SELECT_OFFSET, 32'h0005);
    rd(PTR_SELECT_OFFSET, q);
    chk(q & 32'h8000, 32'h8000);
    wait_idle();
    rd(PTR_DATA_OFFSET, q);
    chk(q, 32'h005);
    rd(PTR_SELECT_OFFSET, q);
    chk(q, 32'h41FF);
    wr(PTR_SELECT_OFFSET, 32'h4005);
    wait_idle();
    rd(PTR_DATA_OFFSET, q);
    chk(q, 32'h1FF);
  endtask : t_ptr
  task automatic t_dma;
    logic [31:0] q;
    for (int x = 1; x < 8; x++) begin
      xfer <= x[2:0];
      repeat (2) @(posedge clk);
      chk({27'h0, merge, max_blk}, 32'(x + 1));
    end
    xfer <= 3'h0;
    wr(GLOBAL_CONFIG_OFFSET, 32'h7);
    rd(GLOBAL_CONFIG_OFFSET, q);
    chk(q, 32'h7);
    chk({27'h0, merge, max_blk}, 32'h1);
    for (int b = 0; b < 8; b++) begin
      wr(GLOBAL_CONFIG_OFFSET, 32'hFFFFFCF8 | b);
      rd(GLOBAL_CONFIG_OFFSET, q);
      chk(q, 32'h80 | b);
      chk({27'h0, merge, max_blk}, 32'h10 + b + 1);
    end
  endtask : t_dma
  task automatic t_ser(input logic msb, input logic sm, input logic sv, input logic [7:0] d);
    logic [7:0] e;
    wr(GLOBAL_CONFIG_OFFSET, {22'h0, sv, msb, 8'h00});
    reg_write <= 1'b0;
    stuff_mode <= sm;
    send <= 1'b1;
    send_byte <= d;
    @(posedge clk);
    send <= 1'b0;
    repeat (200) begin
      @(negedge clk);
      if (rx_count === 4'h8) break;
    end
    e = d;
    if (!msb) e = {<<{d}};
    if (sm) e[0] = sv;
    chk({28'h0, rx_count}, 32'h8);
    chk({24'h0, rx_byte}, {24'h0, e});
    @(posedge clk);
  endtask : t_ser
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst, reg_write, reg_read, stuff_mode, send, xfer} = 8'h80;
    {reg_addr, reg_wdata, send_byte} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ptr();
    t_dma();
    t_ser(1'b0, 1'b0, 1'b0, 8'hB4);
    t_ser(1'b1, 1'b0, 1'b1, 8'hB4);
    t_ser(1'b1, 1'b1, 1'b1, 8'hB4);
    t_ser(1'b0, 1'b1, 1'b0, 8'hFF);
    finish_test();
  end
  // hang guard, well beyond the few hundred cycles the run needs
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
endmodule : test_tx_frame_fifo_pointer_config
`default_nettype wire
